//--- shared/dac_link_pkg.sv
// Package of constants and types for the dual converter serial port.
package dac_link_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned ADDR_POS = 16;
    localparam int unsigned RW_POS = 23;
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [15:0] RESET_CODE = 16'h0000;
    localparam logic [23:0] RESET_WORD = 24'h000000;
    localparam logic [4:0] RESET_COUNT = 5'h00;

    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic data;
        logic load_n;
        logic clear_n;
    } link_pins_t;

    typedef struct packed {
        logic [15:0] code_a;
        logic [15:0] code_b;
    } dac_codes_t;
endpackage

//--- logic/dual_dac_serial_load_update.sv
// Serial write port and update control of the dual voltage-output converter.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_update (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire dac_link_pkg::link_pins_t pins,
    input wire logic bipolar_coding_select,
    input wire logic bipolar_range,
    input wire logic clear_to_midscale,
    output logic serial_out,
    output dac_link_pkg::dac_codes_t converter_codes
);
    logic [2:0] frame_s;
    logic [2:0] sclk_s;
    logic [2:0] data_s;
    logic [2:0] load_s;
    logic [2:0] clear_s;
    logic [2:0] coding_s;
    logic [2:0] range_s;
    logic [2:0] midscale_s;
    logic frame_q;
    logic sclk_q;
    logic load_q;
    logic data_q;
    logic clear_q;
    logic coding_q;
    logic range_q;
    logic midscale_q;
    logic [23:0] shift;
    logic [23:0] readout;
    logic [4:0] count;
    logic [15:0] input_reg [2];
    logic [15:0] dac_reg [2];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_s <= 3'h7;
            sclk_s <= 3'h7;
            data_s <= 3'h0;
            load_s <= 3'h7;
            clear_s <= 3'h7;
            coding_s <= 3'h0;
            range_s <= 3'h0;
            midscale_s <= 3'h0;
        end
        else
        begin
            frame_s <= {frame_s[1:0], pins.frame_n};
            sclk_s <= {sclk_s[1:0], pins.sclk};
            data_s <= {data_s[1:0], pins.data};
            load_s <= {load_s[1:0], pins.load_n};
            clear_s <= {clear_s[1:0], pins.clear_n};
            coding_s <= {coding_s[1:0], bipolar_coding_select};
            range_s <= {range_s[1:0], bipolar_range};
            midscale_s <= {midscale_s[1:0], clear_to_midscale};
        end
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_q <= 1'b1;
            sclk_q <= 1'b1;
            load_q <= 1'b1;
            data_q <= 1'b0;
            clear_q <= 1'b1;
            coding_q <= 1'b0;
            range_q <= 1'b0;
            midscale_q <= 1'b0;
        end
        else
        begin
            if (frame_s[1] == frame_s[2])
                frame_q <= frame_s[2];
            if (sclk_s[1] == sclk_s[2])
                sclk_q <= sclk_s[2];
            if (load_s[1] == load_s[2])
                load_q <= load_s[2];
            if (data_s[1] == data_s[2])
                data_q <= data_s[2];
            if (clear_s[1] == clear_s[2])
                clear_q <= clear_s[2];
            if (coding_s[1] == coding_s[2])
                coding_q <= coding_s[2];
            if (range_s[1] == range_s[2])
                range_q <= range_s[2];
            if (midscale_s[1] == midscale_s[2])
                midscale_q <= midscale_s[2];
        end
    end

    wire frame_f = frame_s[1] == frame_s[2] ? frame_s[2] : frame_q;
    wire sclk_f = sclk_s[1] == sclk_s[2] ? sclk_s[2] : sclk_q;
    wire load_f = load_s[1] == load_s[2] ? load_s[2] : load_q;
    wire clear_f = clear_s[1] == clear_s[2] ? clear_s[2] : clear_q;
    wire data_f = data_s[1] == data_s[2] ? data_s[2] : data_q;
    wire coding_f = coding_s[1] == coding_s[2] ? coding_s[2] : coding_q;
    wire range_f = range_s[1] == range_s[2] ? range_s[2] : range_q;
    wire midscale_f = midscale_s[1] == midscale_s[2] ? midscale_s[2] : midscale_q;
    wire sclk_fall = sclk_q & ~sclk_f;
    wire sclk_rise = ~sclk_q & sclk_f;
    wire frame_rise = ~frame_q & frame_f;
    wire frame_fall = frame_q & ~frame_f;
    wire load_fall = load_q & ~load_f;
    wire shift_now = sclk_fall & ~frame_f;
    // The first echo bit leaves at frame start, the others after each rising clock edge.
    wire echo_step = frame_fall | (sclk_rise & ~frame_f);
    wire word_ok = frame_rise & (count == 5'(dac_link_pkg::WORD_W)) & ~shift[dac_link_pkg::RW_POS];
    wire chan = shift[dac_link_pkg::ADDR_POS];
    wire [15:0] clear_code = midscale_f ? dac_link_pkg::MID_CODE : dac_link_pkg::ZERO_CODE;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shift <= dac_link_pkg::RESET_WORD;
            readout <= dac_link_pkg::RESET_WORD;
            count <= dac_link_pkg::RESET_COUNT;
            serial_out <= 1'b0;
        end
        else
        begin
            if (shift_now)
            begin
                shift <= {shift[22:0], data_f};
                if (count != 5'h1f)
                    count <= count + 5'h01;
            end
            if (echo_step)
            begin
                serial_out <= readout[23];
                readout <= {readout[22:0], 1'b0};
            end
            if (frame_rise)
            begin
                count <= dac_link_pkg::RESET_COUNT;
                readout <= shift;
            end
        end
    end

    // Strap high means offset binary; two's complement flips the top bit.
    wire [15:0] offset_word = (range_f & ~coding_f) ?
        {~shift[15], shift[14:0]} : shift[15:0];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 2; i++)
            begin
                input_reg[i] <= dac_link_pkg::RESET_CODE;
                dac_reg[i] <= dac_link_pkg::RESET_CODE;
            end
        end
        else
        begin
            if (word_ok)
                input_reg[chan] <= offset_word;
            if (!clear_f)
            begin
                dac_reg[0] <= clear_code;
                dac_reg[1] <= clear_code;
            end
            else if (load_fall)
            begin
                dac_reg[0] <= input_reg[0];
                dac_reg[1] <= input_reg[1];
            end
            else if (word_ok & ~load_f)
                dac_reg[chan] <= offset_word;
        end
    end

    assign converter_codes.code_a = dac_reg[0];
    assign converter_codes.code_b = dac_reg[1];

    sequence s_deferred_write;
        word_ok && load_f && clear_f;
    endsequence

    sequence s_direct_write;
        word_ok && !load_f && clear_f && !load_fall;
    endsequence

    a_shift_on_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !shift_now |=> $stable(shift) || $past(frame_rise)) else $error("Shift moved without fall.");
    a_shift_takes_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        shift_now |=> shift == {$past(shift[22:0]), $past(data_f)})
        else $error("Shift lost a bit.");
    a_word_on_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !frame_rise |=> $stable(input_reg[0]) && $stable(input_reg[1]))
        else $error("Input register moved outside frame end.");
    a_echo_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        echo_step |=> serial_out == $past(readout[23]))
        else $error("Serial output missed a bit.");
    a_defer_with_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_deferred_write |=> $stable(dac_reg[0]) && $stable(dac_reg[1]))
        else $error("Converter updated while load high.");
    a_load_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
        load_fall && clear_f |=> dac_reg[0] == $past(input_reg[0]) && dac_reg[1] == $past(input_reg[1]))
        else $error("Simultaneous load failed.");
    a_clear_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !clear_f |=> dac_reg[0] == $past(clear_code)) else $error("Clear code wrong.");
    a_direct_update: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_direct_write |=> ($past(chan) ? dac_reg[1] : dac_reg[0]) == $past(offset_word))
        else $error("Direct update missed.");
endmodule // dual_dac_serial_load_update
`default_nettype wire

//--- tb/link_host.sv
// Host serial port model that frames and shifts words into the converter.
`timescale 1ns/1ps
`default_nettype none
module link_host (
    input wire logic sys_clk,
    input wire logic serial_out,
    output var logic frame_n,
    output var logic sclk,
    output var logic data,
    output var logic [23:0] echoed
);
    initial
    begin
        frame_n = 1'b1;
        sclk = 1'b1;
        data = 1'b0;
        echoed = 24'h000000;
    end
    task automatic send(input logic [23:0] word);
        frame_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            data = word[i];
            repeat (4) @(negedge sys_clk);
            echoed = {echoed[22:0], serial_out};
            sclk = 1'b0;
            repeat (4) @(negedge sys_clk);
            sclk = 1'b1;
        end
        data = ~word[0];
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic close();
        frame_n = 1'b1;
    endtask
endmodule // link_host
`default_nettype wire

//--- tb/dual_dac_serial_load_update_bench.sv
// Testbench for the converter serial write port and update control.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_update_bench;
    logic sys_clk, reset_n, frame_n, sclk, data, load_n, clear_n, coding, bipolar, mid, serial_out;
    dac_link_pkg::dac_codes_t codes;
    logic [23:0] echoed;
    int errors;
    int num_checks;
    link_host host (.sys_clk(sys_clk), .serial_out(serial_out), .frame_n(frame_n), .sclk(sclk),
        .data(data), .echoed(echoed));
    dual_dac_serial_load_update uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .pins({frame_n, sclk, data, load_n, clear_n}), .bipolar_coding_select(coding),
        .bipolar_range(bipolar), .clear_to_midscale(mid), .serial_out(serial_out),
        .converter_codes(codes));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic write(input logic ch, input logic [15:0] v);
        host.send({7'h00, ch, v});
        host.close();
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic direct_update();
        load_n = 1'b0;
        host.send({8'h00, 16'h1234});
        check("code_a early", 16'h0000, codes.code_a);
        host.close();
        repeat (10) @(negedge sys_clk);
        check("code_a", 16'h1234, codes.code_a);
        write(1'b1, 16'habcd);
        check("echo low", 16'h1234, echoed[15:0]);
        check("code_b", 16'habcd, codes.code_b);
        check("code_a kept", 16'h1234, codes.code_a);
    endtask
    task automatic deferred_update();
        load_n = 1'b1;
        write(1'b0, 16'h1111);
        check("echo chan", 16'h0001, {8'h00, echoed[23:16]});
        check("echo data", 16'habcd, echoed[15:0]);
        write(1'b1, 16'h2222);
        check("code_a held", 16'h1234, codes.code_a);
        check("code_b held", 16'habcd, codes.code_b);
        load_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        check("code_a load", 16'h1111, codes.code_a);
        check("code_b load", 16'h2222, codes.code_b);
    endtask
    task automatic coding_modes();
        bipolar = 1'b1;
        write(1'b0, 16'h0005);
        check("twos", 16'h8005, codes.code_a);
        coding = 1'b1;
        write(1'b0, 16'h0006);
        check("offset", 16'h0006, codes.code_a);
        bipolar = 1'b0;
        coding = 1'b0;
        write(1'b0, 16'h0007);
        check("straight", 16'h0007, codes.code_a);
    endtask
    task automatic clear_codes();
        clear_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        check("zero", 16'h0000, codes.code_b);
        mid = 1'b1;
        repeat (10) @(negedge sys_clk);
        check("mid", 16'h8000, codes.code_a);
        clear_n = 1'b1;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        {load_n, clear_n, coding, bipolar, mid} = 5'h18;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        direct_update();
        deferred_update();
        coding_modes();
        clear_codes();
        end_sim();
    end
endmodule // dual_dac_serial_load_update_bench
`default_nettype wire
